/* hw/fmds_pkg.sv */
// Constants and carriers for the fault mask and diagnostic status block
`default_nettype none
package fmds_pkg;
  localparam int          NUM_CH         = 6;
  localparam logic [7:0]  OPEN_ADDR      = 8'h1b;
  localparam logic [7:0]  GSHORT_ADDR    = 8'h1c;
  localparam logic [7:0]  SLED_ADDR      = 8'h1d;
  localparam logic [7:0]  MASK_ADDR      = 8'h1e;
  localparam logic [7:0]  DIAGNOSTIC_STATUS_ADDR      = 8'h1f;
  localparam logic [4:0]  MASK_RESET     = 5'h00;
  localparam int          MASK_WIDTH     = 5;
  localparam int          MSK_BOOST      = 4;
  localparam int          MSK_OPEN       = 3;
  localparam int          MSK_GSHORT     = 2;
  localparam int          MSK_TWARN      = 1;
  localparam int          MSK_SLED       = 0;
  localparam int          DG_REF         = 5;
  localparam int          DG_BUV         = 4;
  localparam int          DG_BOV         = 3;
  localparam int          DG_PWRUP       = 2;
  localparam int          DG_TWARN       = 1;
  localparam int          DG_TSHUT       = 0;
  localparam logic [7:0]  RDATA_RESET    = 8'h00;
  localparam logic        PWRUP_RESET    = 1'h1;
  localparam logic        PIN_RELEASED   = 1'h1;
  localparam logic        ENABLE_RESET   = 1'h0;

  // Raw conditions from the analog detectors
  typedef struct packed {
    logic              ref_out_of_range;
    logic              boost_uv;
    logic              boost_ov;
    logic              temp_warn;
    logic              temp_shut;
    logic [NUM_CH-1:0] ch_open;
    logic [NUM_CH-1:0] ch_gshort;
    logic [NUM_CH-1:0] ch_sled;
  } fmds_det_s;

  // Register access request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fmds_req_s;
endpackage : fmds_pkg
`default_nettype wire

/* hw/fmds_top.sv */
// Fault mask and diagnostic status register logic
`timescale 1ns/100ps
`default_nettype none
module fmds_top (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Register access from the serial interface
  input  wire fmds_pkg::fmds_req_s req,
  output var  logic [7:0]         rdata,
  // Detector inputs, asynchronous
  input  wire fmds_pkg::fmds_det_s det_in,
  // Controls and pin
  output var  logic               run_enable,
  output var  logic               boost_enable,
  output var  logic               fault_out_n
);
  //////////////////////////////////////////////////////////////////////////
  // Synchronisers
  fmds_pkg::fmds_det_s det_meta_reg;
  fmds_pkg::fmds_det_s det_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      det_meta_reg <= '0;
    end else begin
      det_meta_reg <= det_in;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request decode
  logic sel_open;
  logic sel_gshort;
  logic sel_sled;
  logic sel_mask;
  logic sel_diagnostic_status;
  logic mask_wr;
  logic diagnostic_status_rd;

  always_comb begin
    sel_open   = 1'h0;
    sel_gshort = 1'h0;
    sel_sled   = 1'h0;
    sel_mask   = 1'h0;
    sel_diagnostic_status   = 1'h0;
    if (req.addr == fmds_pkg::OPEN_ADDR) begin
      sel_open = 1'h1;
    end else if (req.addr == fmds_pkg::GSHORT_ADDR) begin
      sel_gshort = 1'h1;
    end else if (req.addr == fmds_pkg::SLED_ADDR) begin
      sel_sled = 1'h1;
    end else if (req.addr == fmds_pkg::MASK_ADDR) begin
      sel_mask = 1'h1;
    end else if (req.addr == fmds_pkg::DIAGNOSTIC_STATUS_ADDR) begin
      sel_diagnostic_status = 1'h1;
    end
  end

  // Writes to read-only words are ignored
  always_comb begin
    mask_wr = req.wr && sel_mask;
    diagnostic_status_rd = req.rd && sel_diagnostic_status;
  end

  //////////////////////////////////////////////////////////////////////////
  // Mask register
  logic [fmds_pkg::MASK_WIDTH-1:0] mask_wdata;
  logic [fmds_pkg::MASK_WIDTH-1:0] mask_reg;

  // Upper bits have no storage
  always_comb begin
    mask_wdata = req.wdata[fmds_pkg::MASK_WIDTH-1:0];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= fmds_pkg::MASK_RESET;
    end else if (mask_wr) begin
      mask_reg <= mask_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power-up indication
  logic pwrup_reg;

  // Only reset sets it, so no set and clear race
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwrup_reg <= fmds_pkg::PWRUP_RESET;
    end else if (diagnostic_status_rd) begin
      pwrup_reg <= 1'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status word
  logic [7:0] diagnostic_status;

  always_comb begin
    diagnostic_status = 8'h00;
    diagnostic_status[fmds_pkg::DG_REF]   = det_reg.ref_out_of_range;
    diagnostic_status[fmds_pkg::DG_BUV]   = det_reg.boost_uv;
    diagnostic_status[fmds_pkg::DG_BOV]   = det_reg.boost_ov;
    diagnostic_status[fmds_pkg::DG_PWRUP] = pwrup_reg;
    diagnostic_status[fmds_pkg::DG_TWARN] = det_reg.temp_warn;
    diagnostic_status[fmds_pkg::DG_TSHUT] = det_reg.temp_shut;
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-channel readback words
  logic [7:0] open_word;
  logic [7:0] gshort_word;
  logic [7:0] sled_word;

  // Bits past the last channel read zero
  for (genvar ch = 0; ch < $bits(open_word); ch++) begin : g_chan
    if (ch < fmds_pkg::NUM_CH) begin : g_used
      assign open_word[ch]   = det_reg.ch_open[ch];
      assign gshort_word[ch] = det_reg.ch_gshort[ch];
      assign sled_word[ch]   = det_reg.ch_sled[ch];
    end else begin : g_spare
      assign open_word[ch]   = 1'h0;
      assign gshort_word[ch] = 1'h0;
      assign sled_word[ch]   = 1'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = fmds_pkg::RDATA_RESET;
    if (sel_open) begin
      rdata_next = open_word;
    end else if (sel_gshort) begin
      rdata_next = gshort_word;
    end else if (sel_sled) begin
      rdata_next = sled_word;
    end else if (sel_mask) begin
      rdata_next = {3'h0, mask_reg};
    end else if (sel_diagnostic_status) begin
      rdata_next = diagnostic_status;
    end
  end

  // Read data holds between reads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= fmds_pkg::RDATA_RESET;
    end else if (req.rd) begin
      rdata <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Operation control
  logic halt_all;

  always_comb begin
    halt_all = det_reg.ref_out_of_range || det_reg.temp_shut;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_enable <= fmds_pkg::ENABLE_RESET;
    end else begin
      run_enable <= !halt_all;
    end
  end

  // Undervoltage stops the boost only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boost_enable <= fmds_pkg::ENABLE_RESET;
    end else begin
      boost_enable <= !halt_all && !det_reg.boost_uv;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault classes, one per mask bit
  logic [fmds_pkg::MASK_WIDTH-1:0] class_raw;
  logic [fmds_pkg::MASK_WIDTH-1:0] class_hit;
  logic                            fault_any;

  always_comb begin
    class_raw = '0;
    class_raw[fmds_pkg::MSK_BOOST]  = det_reg.boost_uv
                                      || det_reg.boost_ov;
    class_raw[fmds_pkg::MSK_OPEN]   = |det_reg.ch_open;
    class_raw[fmds_pkg::MSK_GSHORT] = |det_reg.ch_gshort;
    class_raw[fmds_pkg::MSK_TWARN]  = det_reg.temp_warn;
    class_raw[fmds_pkg::MSK_SLED]   = |det_reg.ch_sled;
  end

  // A set mask bit keeps its class off the pin
  for (genvar b = 0; b < fmds_pkg::MASK_WIDTH; b++) begin : g_class
    assign class_hit[b] = class_raw[b] && !mask_reg[b];
  end

  always_comb begin
    fault_any = |class_hit;
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_out_n <= fmds_pkg::PIN_RELEASED;
    end else begin
      fault_out_n <= !fault_any;
    end
  end
endmodule // fmds_top
`default_nettype wire

/* verification/fmds_sva.sv */
// Checker for the fault mask and diagnostic status block
`timescale 1ns/100ps
`default_nettype none
module fmds_sva (
  // Block ports
  input wire logic                clk,
  input wire logic                resetn,
  input wire fmds_pkg::fmds_req_s req,
  input wire logic [7:0]          rdata,
  input wire fmds_pkg::fmds_det_s det_in,
  input wire logic                run_enable,
  input wire logic                boost_enable,
  input wire logic                fault_out_n
);
  logic [4:0] mask_q;
  logic       seen_q;
  logic       fexp;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) mask_q <= 5'h00;
    else if (req.wr && req.addr == 8'h1e) mask_q <= req.wdata[4:0];
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) seen_q <= 1'h0;
    else if (req.rd && req.addr == 8'h1f) seen_q <= 1'h1;
  assign fexp = ((det_in.boost_uv | det_in.boost_ov) & !mask_q[4])
    | (|det_in.ch_open & !mask_q[3]) | (|det_in.ch_gshort & !mask_q[2])
    | (det_in.temp_warn & !mask_q[1]) | (|det_in.ch_sled & !mask_q[0]);
  sequence quiet;
    ($stable(det_in) && $stable(mask_q)) [*4];
  endsequence
  pin_map_a: assert property (quiet |-> fault_out_n == !fexp)
    else $error("fault pin wrong");
  ref_halt_a: assert property (quiet ##0 det_in.ref_out_of_range
    |-> !run_enable && !boost_enable) else $error("no halt");
  uv_boost_a: assert property (quiet ##0 det_in.boost_uv
    |-> !boost_enable) else $error("boost still on");
  hot_stop_a: assert property (quiet ##0 det_in.temp_shut
    |-> !run_enable && !boost_enable) else $error("no shutdown");
  rd_hold_a: assert property (!req.rd |=> $stable(rdata))
    else $error("read data moved");
  unmap_rd_a: assert property (req.rd && !(req.addr inside {[8'h1b:8'h1f]})
    |=> rdata == 8'h00) else $error("unmapped read");
  mask_rd_a: assert property (req.rd && req.addr == 8'h1e
    |=> rdata == {3'h0, $past(mask_q)}) else $error("mask readback");
  pwrup_rd_a: assert property (req.rd && req.addr == 8'h1f
    |=> rdata[2] == !$past(seen_q)) else $error("power-up bit");
endmodule // fmds_sva
bind fmds_top fmds_sva sva_i (.clk(clk), .resetn(resetn), .req(req),
  .rdata(rdata), .det_in(det_in), .run_enable(run_enable),
  .boost_enable(boost_enable), .fault_out_n(fault_out_n));
`default_nettype wire

/* verification/fmds_host.sv */
// Host model issuing single register accesses
`timescale 1ns/100ps
`default_nettype none
module fmds_host (
  // Bus
  input  wire logic                clk,
  output var  fmds_pkg::fmds_req_s req,
  input  wire logic [7:0]          rdata
);
  logic [7:0] got;
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1 got = rdata;
  endtask
endmodule // fmds_host
`default_nettype wire

/* verification/tb_top.sv */
// Bench for the fault mask and diagnostic status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  logic                clk = 0;
  logic                resetn = 0;
  logic [7:0]          rdata;
  logic                run_en, boost_en, flt_n;
  fmds_pkg::fmds_req_s req;
  fmds_pkg::fmds_det_s det = '0;
  int                  bad_count = 0;
  int                  compares = 0;
  fmds_host host (.clk(clk), .req(req), .rdata(rdata));
  fmds_top DUT (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
    .det_in(det), .run_enable(run_en), .boost_enable(boost_en),
    .fault_out_n(flt_n));
  initial forever #4 clk = ~clk;
  task automatic rd(input logic [7:0] a, e);
    host.acc(1'h0, a, 8'h00);
    `CHK("rdata", e, host.got)
  endtask
  task automatic put(input fmds_pkg::fmds_det_s d);
    @(posedge clk);
    det <= d;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_mask;
    fmds_pkg::fmds_det_s d[5] = '{23'h000020, 23'h080000, 23'h000040,
      23'h020000, 23'h100000};
    for (int i = 0; i < 5; i++) begin
      host.acc(1'h1, 8'h1e, 8'h00);
      put(d[i]);
      `CHK("pin", 1'h0, flt_n)
      host.acc(1'h1, 8'h1e, 8'he0 | (8'h01 << i));
      put(d[i]);
      `CHK("pin", 1'h1, flt_n)
      rd(8'h1e, 8'h01 << i);
    end
    put(23'h200000);
    `CHK("pin", 1'h1, flt_n)
    host.acc(1'h1, 8'h1e, 8'h0f);
    put(23'h200000);
    `CHK("pin", 1'h0, flt_n)
  endtask
  task automatic t_pwrup;
    rd(8'h1f, 8'h04);
    rd(8'h1f, 8'h00);
  endtask
  task automatic t_diagnostic_status(input fmds_pkg::fmds_det_s d, input logic [7:0] e,
      input logic [1:0] en);
    put(d);
    rd(8'h1f, e);
    `CHK("enables", en, {run_en, boost_en})
  endtask
  task automatic t_chan;
    put(23'h020084);
    rd(8'h1b, 8'h20);
    rd(8'h1c, 8'h02);
    rd(8'h1d, 8'h04);
    rd(8'h20, 8'h00);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    t_pwrup;
    t_mask;
    t_diagnostic_status(23'h400000, 8'h20, 2'h0);
    t_diagnostic_status(23'h200000, 8'h10, 2'h2);
    t_diagnostic_status(23'h040000, 8'h01, 2'h0);
    t_diagnostic_status(23'h080000, 8'h02, 2'h3);
    t_chan;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
